// ---- core/afcr_config_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// (RQ1) Pin bit: zero powers down, one standby
// (RQ2) Channel mode: 01 down, 10 standby
// (RQ3) Divider phase delays sync zero to six
// (RQ4) Output mode: type, drive, enable, invert, format
// (RQ5) Nonzero divide forces duty corrector on
// (RQ6) Shadowed writes apply only on transfer
// (RQ7) Local writes follow channel index bits
// (RQ8) Both channels selected: read returns first
module afcr_config_regs
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic pdwn_pin,
  input wire logic divider_sync_in,
  output logic divider_sync_out,
  output logic [afcr_pkg::NUM_CH-1:0] dev_full_power_down,
  output logic [afcr_pkg::NUM_CH-1:0] dev_standby,
  output logic [afcr_pkg::DIV_W-1:0] clk_div_sel,
  output logic duty_cycle_corrector_en,
  output logic [afcr_pkg::PHASE_W-1:0] divider_phase,
  output logic output_data_clock_invert,
  output logic drive_reduced,
  output logic output_lvds,
  output logic [afcr_pkg::NUM_CH-1:0] output_enable_n,
  output logic [afcr_pkg::NUM_CH-1:0] output_invert,
  output logic [afcr_pkg::NUM_CH-1:0] twos_complement,
  output logic [afcr_pkg::NUM_CH-1:0] gray_code,
  output logic [afcr_pkg::NUM_CH-1:0][afcr_pkg::TEST_W-1:0] test_pattern,
  output logic [afcr_pkg::NUM_CH-1:0] long_prbs_generator_reset,
  output logic [afcr_pkg::NUM_CH-1:0] short_prbs_generator_reset,
  output logic [afcr_pkg::NUM_CH-1:0] self_test_en,
  output logic [afcr_pkg::NUM_CH-1:0] self_test_restart,
  output logic [afcr_pkg::NUM_CH-1:0][afcr_pkg::TRIM_W-1:0] offset_trim_val
);
  import afcr_pkg::*;

  typedef logic [NUM_CH-1:0][NUM_SLOT-1:0][DATA_W-1:0] afcr_bank_type;

  afcr_bank_type master_q, master_d, active_q, active_d;
  logic [NUM_CH-1:0] chan_q, chan_d;
  logic [NUM_CH-1:0] pd_q, pd_d, sb_q, sb_d;
  logic [NUM_CH-1:0] twos_q, twos_d, gray_q, gray_d;
  logic dcs_q, dcs_d, ext_standby, xfer, hit;
  logic [2:0] slot;
  logic [MODE_W-1:0] mode;
  logic [FMT_W-1:0] fmt;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic wr_en;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_DEPTH-1:0] hist_q, hist_d;

  // Maps an address onto its shadowed slot, top bit flags a hit
  function automatic logic [3:0] slot_lookup(
    input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < NUM_SLOT; i++)
    begin
      if (a == SLOT_ADDR[i])
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // Global bits always take the write, local bits only if selected
  function automatic logic [DATA_W-1:0] merge_byte(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw,
    input logic [2:0] s,
    input logic sel);
    return (nw & SLOT_GMASK[s]) | ((sel ? nw : old) & SLOT_LMASK[s]);
  endfunction

  afcr_spi_port u_spi
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_en(wr_en),
    .wr_data(wr_data)
  );

  assign {hit, slot} = slot_lookup(reg_addr);

  // Master copies take writes; live copies load only on transfer
  always_comb
  begin
    master_d = master_q;
    chan_d = chan_q;
    active_d = active_q;
    xfer = 1'b0;
    if (wr_en)
    begin
      if (reg_addr == ADDR_CHAN_INDEX)
        chan_d = wr_data[NUM_CH-1:0];
      else if (reg_addr == ADDR_TRANSFER)
        xfer = wr_data[XFER_BIT]; // RQ6
      else if (hit)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          master_d[c][slot] = merge_byte(master_q[c][slot], wr_data,
            slot, chan_q[c]); // RQ7
        end
      end
    end
    // Transfer bit is never stored, so it clears by itself
    if (xfer)
      active_d = master_q; // RQ6
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        master_q[c] <= SLOT_RESET;
        active_q[c] <= SLOT_RESET;
      end
      chan_q <= CHAN_INDEX_RESET;
    end
    else
    begin
      master_q <= master_d;
      active_q <= active_d;
      chan_q <= chan_d;
    end
  end

  // Readback shows master copies, so unapplied writes are visible
  always_comb
  begin
    rd_data = '0;
    if (reg_addr == ADDR_CHAN_INDEX)
      rd_data[NUM_CH-1:0] = chan_q;
    else if (hit)
      rd_data = chan_q[CH_A] ? master_q[CH_A][slot]
                             : master_q[CH_B][slot]; // RQ8
  end

  // Decoded controls, registered so the pins see no glitches
  always_comb
  begin
    ext_standby = active_q[CH_A][SLOT_POWER][EXT_PIN_BIT];
    mode = '0;
    fmt = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      mode = active_q[c][SLOT_POWER][MODE_W-1:0];
      fmt = active_q[c][SLOT_OUT][FMT_W-1:0];
      pd_d[c] = (pdwn_pin && !ext_standby) || mode == PM_FULL_PD; // RQ1 RQ2
      sb_d[c] = !pd_d[c] && ((pdwn_pin && ext_standby)
        || mode == PM_STANDBY); // RQ1 RQ2
      twos_d[c] = (fmt == FMT_TWOS); // RQ4
      gray_d[c] = (fmt == FMT_GRAY); // RQ4
    end
    dcs_d = active_q[CH_A][SLOT_GCLK][DCS_BIT]
      || (active_q[CH_A][SLOT_CDIV][DIV_W-1:0] != '0); // RQ5
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pd_q <= '0;
      sb_q <= '0;
      twos_q <= '0;
      gray_q <= '0;
      dcs_q <= 1'b1;
    end
    else
    begin
      pd_q <= pd_d;
      sb_q <= sb_d;
      twos_q <= twos_d;
      gray_q <= gray_d;
      dcs_q <= dcs_d;
    end
  end

  // Sync delay line; reserved code 111 is held at six cycles
  always_comb
  begin
    hist_d = {hist_q[PHASE_DEPTH-2:0], divider_sync_in};
    phase = active_q[CH_A][SLOT_PHASE][PHASE_W-1:0];
    if (phase > PHASE_MAX)
      phase = PHASE_MAX;
    divider_sync_out = (phase == '0) ? divider_sync_in
      : hist_q[3'(phase - 3'h1)]; // RQ3
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      hist_q <= '0;
    else
      hist_q <= hist_d;
  end

  // Plain fields straight from the live copies
  always_comb
  begin
    clk_div_sel = active_q[CH_A][SLOT_CDIV][DIV_W-1:0];
    divider_phase = active_q[CH_A][SLOT_PHASE][PHASE_W-1:0];
    output_data_clock_invert = active_q[CH_A][SLOT_PHASE][DCO_INV_BIT];
    drive_reduced = active_q[CH_A][SLOT_OUT][DRIVE_BIT]; // RQ4
    output_lvds = active_q[CH_A][SLOT_OUT][LVDS_BIT]; // RQ4
    for (int c = 0; c < NUM_CH; c++)
    begin
      output_enable_n[c] = active_q[c][SLOT_OUT][OE_N_BIT]; // RQ4
      output_invert[c] = active_q[c][SLOT_OUT][INVERT_BIT]; // RQ4
      test_pattern[c] = active_q[c][SLOT_TEST][TEST_W-1:0];
      long_prbs_generator_reset[c] = active_q[c][SLOT_TEST][LONG_RST_BIT];
      short_prbs_generator_reset[c] = active_q[c][SLOT_TEST][SHORT_RST_BIT];
      self_test_en[c] = active_q[c][SLOT_BIST][BIST_EN_BIT];
      self_test_restart[c] = active_q[c][SLOT_BIST][BIST_RST_BIT];
      offset_trim_val[c] = active_q[c][SLOT_OFFS][TRIM_W-1:0];
    end
  end

  assign dev_full_power_down = pd_q;
  assign dev_standby = sb_q;
  assign duty_cycle_corrector_en = dcs_q;
  assign twos_complement = twos_q;
  assign gray_code = gray_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_pin_standby_role: assert property ( // RQ1
    (pdwn_pin && ext_standby) |=> (dev_standby | dev_full_power_down)
      == 2'h3)
    else $error("pin did not give standby");
  a_pin_powerdown_role: assert property ( // RQ1
    (pdwn_pin && !ext_standby) |=> dev_full_power_down == 2'h3
      && dev_standby == 2'h0)
    else $error("pin did not power down");
  a_chan_mode_decode: assert property ( // RQ2
    (!pdwn_pin && active_q[CH_B][SLOT_POWER][MODE_W-1:0] == 2'h2)
      |=> dev_standby[CH_B] && !dev_full_power_down[CH_B])
    else $error("mode 10 not decoded as standby");
  a_phase_two_delay: assert property ( // RQ3
    (divider_phase == 3'h2 && divider_sync_in && !xfer) ##1 !xfer
      |=> divider_sync_out)
    else $error("sync not delayed by two cycles");
  a_format_gray_sel: assert property ( // RQ4
    (active_q[CH_B][SLOT_OUT][FMT_W-1:0] == 2'h2) |=> gray_code[CH_B]
      && !twos_complement[CH_B])
    else $error("gray format not decoded");
  a_dcs_forced_on: assert property ( // RQ5
    (active_q[CH_A][SLOT_CDIV][DIV_W-1:0] != 3'h0)
      |=> duty_cycle_corrector_en)
    else $error("divider did not force corrector");
  a_shadow_hold: assert property ( // RQ6
    (wr_en && hit) |=> active_q == $past(active_q))
    else $error("shadowed write reached live copy");
  a_xfer_apply: assert property ( // RQ6
    xfer |=> active_q == $past(master_q))
    else $error("transfer did not apply masters");
  a_global_both_chans: assert property ( // RQ7
    (wr_en && hit) |=> ((master_q[CH_A][$past(slot)]
      ^ master_q[CH_B][$past(slot)]) & SLOT_GMASK[$past(slot)]) == 8'h00)
    else $error("global bits differ between channels");
  a_read_first_chan: assert property ( // RQ8
    (hit && chan_q == 2'h3) |-> rd_data == master_q[CH_A][slot])
    else $error("dual select read not channel A");
endmodule

// ---- core/afcr_pkg.sv ----
package afcr_pkg;
  // Serial frame shape: 16 instruction bits then one data byte
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] INSTR_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h18;
  localparam int RNW_POS = 15;

  // Channel handling
  localparam int NUM_CH = 2;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam logic [NUM_CH-1:0] CHAN_INDEX_RESET = 2'h3;

  // Addresses outside the shadowed block
  localparam logic [ADDR_W-1:0] ADDR_CHAN_INDEX = 13'h005;
  localparam logic [ADDR_W-1:0] ADDR_TRANSFER = 13'h0FF;
  localparam int XFER_BIT = 0;

  // Shadowed block, one slot per address
  localparam int NUM_SLOT = 8;
  localparam logic [2:0] SLOT_POWER = 3'h0;
  localparam logic [2:0] SLOT_GCLK = 3'h1;
  localparam logic [2:0] SLOT_CDIV = 3'h2;
  localparam logic [2:0] SLOT_TEST = 3'h3;
  localparam logic [2:0] SLOT_BIST = 3'h4;
  localparam logic [2:0] SLOT_OFFS = 3'h5;
  localparam logic [2:0] SLOT_OUT = 3'h6;
  localparam logic [2:0] SLOT_PHASE = 3'h7;
  localparam logic [NUM_SLOT-1:0][ADDR_W-1:0] SLOT_ADDR = {13'h016,
    13'h014, 13'h010, 13'h00E, 13'h00D, 13'h00B, 13'h009, 13'h008};
  // Bits shared by both channels, and bits kept per channel
  localparam logic [NUM_SLOT-1:0][DATA_W-1:0] SLOT_GMASK = {8'h87,
    8'hC0, 8'h00, 8'h00, 8'h00, 8'h07, 8'h01, 8'h20};
  localparam logic [NUM_SLOT-1:0][DATA_W-1:0] SLOT_LMASK = {8'h00,
    8'h17, 8'h3F, 8'h05, 8'h37, 8'h00, 8'h00, 8'h03};
  localparam logic [NUM_SLOT-1:0][DATA_W-1:0] SLOT_RESET = {8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

  // Field positions and widths
  localparam int EXT_PIN_BIT = 5;
  localparam int MODE_W = 2;
  localparam int DCS_BIT = 0;
  localparam int DIV_W = 3;
  localparam int TEST_W = 3;
  localparam int LONG_RST_BIT = 5;
  localparam int SHORT_RST_BIT = 4;
  localparam int BIST_RST_BIT = 2;
  localparam int BIST_EN_BIT = 0;
  localparam int TRIM_W = 6;
  localparam int DRIVE_BIT = 7;
  localparam int LVDS_BIT = 6;
  localparam int OE_N_BIT = 4;
  localparam int INVERT_BIT = 2;
  localparam int FMT_W = 2;
  localparam int DCO_INV_BIT = 7;
  localparam int PHASE_W = 3;
  localparam int PHASE_DEPTH = 6;
  localparam logic [PHASE_W-1:0] PHASE_MAX = 3'h6;

  // Field codes
  localparam logic [MODE_W-1:0] PM_FULL_PD = 2'h1;
  localparam logic [MODE_W-1:0] PM_STANDBY = 2'h2;
  localparam logic [FMT_W-1:0] FMT_TWOS = 2'h1;
  localparam logic [FMT_W-1:0] FMT_GRAY = 2'h2;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'h0,
    SPI_INSTR = 2'h1,
    SPI_DATA = 2'h3
  } afcr_spi_state_type;
endpackage

// ---- core/afcr_spi_port.sv ----
`timescale 1ns/1ns
module afcr_spi_port
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic [afcr_pkg::DATA_W-1:0] rd_data,
  output logic [afcr_pkg::ADDR_W-1:0] reg_addr,
  output logic wr_en,
  output logic [afcr_pkg::DATA_W-1:0] wr_data
);
  import afcr_pkg::*;

  afcr_spi_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [RNW_POS:0] shift_q, shift_d;
  logic [DATA_W-1:0] rd_sh_q, rd_sh_d, wr_data_q, wr_data_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rnw_q, rnw_d, load_q, load_d, sdo_q, sdo_d, oe_n_q, oe_n_d;
  logic wr_en_q, wr_en_d, sclk_q, rise, fall;

  // Serial clock is compared with its last sample, so edges are seen at the first ref_clk edge after them
  assign rise = spi_sclk && !sclk_q;
  assign fall = !spi_sclk && sclk_q;

  // Frame sequencer: bits in on rising, read bits out on falling
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    rnw_d = rnw_q;
    rd_sh_d = rd_sh_q;
    load_d = 1'b0;
    sdo_d = sdo_q;
    oe_n_d = oe_n_q;
    wr_en_d = 1'b0;
    wr_data_d = wr_data_q;
    if (spi_csb_n)
    begin
      state_d = SPI_IDLE;
      cnt_d = '0;
      oe_n_d = 1'b1;
    end
    else
    begin
      case (state_q)
        SPI_IDLE, SPI_INSTR:
        begin
          state_d = SPI_INSTR;
          if (rise)
          begin
            shift_d = {shift_q[RNW_POS-1:0], sdio_in};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == INSTR_LAST)
            begin
              state_d = SPI_DATA;
              rnw_d = shift_d[RNW_POS];
              addr_d = shift_d[ADDR_W-1:0];
              load_d = shift_d[RNW_POS];
            end
          end
        end
        SPI_DATA:
        begin
          // Read byte fetched the cycle after the address settles
          if (load_q)
            rd_sh_d = rd_data;
          if (rise && cnt_q < FRAME_LEN)
          begin
            shift_d = {shift_q[RNW_POS-1:0], sdio_in};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == FRAME_LAST && !rnw_q)
            begin
              wr_en_d = 1'b1;
              wr_data_d = shift_d[DATA_W-1:0];
            end
          end
          if (fall && rnw_q)
          begin
            sdo_d = rd_sh_q[DATA_W-1];
            rd_sh_d = {rd_sh_q[DATA_W-2:0], 1'b0};
            oe_n_d = (cnt_q >= FRAME_LEN);
          end
        end
        default:
          state_d = SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= SPI_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
      addr_q <= '0;
      rnw_q <= 1'b0;
      rd_sh_q <= '0;
      load_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      wr_en_q <= 1'b0;
      wr_data_q <= '0;
      sclk_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      rnw_q <= rnw_d;
      rd_sh_q <= rd_sh_d;
      load_q <= load_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
      wr_en_q <= wr_en_d;
      wr_data_q <= wr_data_d;
      sclk_q <= spi_sclk;
    end
  end

  assign sdio_out = sdo_q;
  assign sdio_oe_n = oe_n_q;
  assign reg_addr = addr_q;
  assign wr_en = wr_en_q;
  assign wr_data = wr_data_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_wr_single_pulse: assert property (wr_en |=> !wr_en)
    else $error("write strobe longer than one cycle");
  a_bus_released: assert property (spi_csb_n |=> sdio_oe_n)
    else $error("data pin driven while deselected");
endmodule

// ---- verif/afcr_host_model.sv ----
`timescale 1ns/1ns
// Host side of the serial control port, one byte per frame
module afcr_host_model
(
  input wire logic ref_clk,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic spi_sclk,
  output logic spi_csb_n,
  output logic sdio_in
);
  logic h_bit;

  // Shared data wire: device wins while its enable is low
  assign sdio_in = sdio_oe_n ? h_bit : sdio_out;

  // Idle frame lines at time zero
  initial
  begin
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    h_bit = 1'b0;
  end

  // Each clock phase held three cycles; long idle gap keeps writes settled
  task automatic xfer(input logic rnw, input logic [12:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    f = {rnw, 2'h0, a, wd};
    rd = 8'h00;
    @(negedge ref_clk);
    spi_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      h_bit = f[i];
      repeat (3) @(negedge ref_clk);
      if (i < 8)
        rd[i] = sdio_in;  // Sampled just before the rise
      spi_sclk = 1'b1;
      repeat (3) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    spi_csb_n = 1'b1;
    h_bit = ~h_bit;  // Stale value never lingers between frames
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// ---- verif/test_adc_function_config_regs.sv ----
`timescale 1ns/1ns
module test_adc_function_config_regs;
  import afcr_pkg::*;
  logic ref_clk, srst, spi_sclk, spi_csb_n, sdio_in, sdio_out, sdio_oe_n;
  logic pdwn_pin, divider_sync_in, divider_sync_out, duty_cycle_corrector_en;
  logic output_data_clock_invert, drive_reduced, output_lvds;
  logic [1:0] dev_full_power_down, dev_standby, output_enable_n;
  logic [1:0] output_invert, twos_complement, gray_code, self_test_en;
  logic [1:0] long_prbs_generator_reset, short_prbs_generator_reset;
  logic [1:0] self_test_restart;
  logic [2:0] clk_div_sel, divider_phase;
  logic [1:0][2:0] test_pattern;
  logic [1:0][5:0] offset_trim_val;
  logic [7:0] r, d;
  logic [1:0][7:0] la, lb, lc;
  logic [1:0] ea, eb;
  int n_fail = 0;
  int checked = 0;
  int k_seen;
  integer seed = 32'h9a44fc34;

  afcr_config_regs DUT (.ref_clk(ref_clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .pdwn_pin(pdwn_pin),
    .divider_sync_in(divider_sync_in), .divider_sync_out(divider_sync_out),
    .dev_full_power_down(dev_full_power_down), .dev_standby(dev_standby),
    .clk_div_sel(clk_div_sel),
    .duty_cycle_corrector_en(duty_cycle_corrector_en),
    .divider_phase(divider_phase),
    .output_data_clock_invert(output_data_clock_invert),
    .drive_reduced(drive_reduced), .output_lvds(output_lvds),
    .output_enable_n(output_enable_n), .output_invert(output_invert),
    .twos_complement(twos_complement), .gray_code(gray_code),
    .test_pattern(test_pattern),
    .long_prbs_generator_reset(long_prbs_generator_reset),
    .short_prbs_generator_reset(short_prbs_generator_reset),
    .self_test_en(self_test_en), .self_test_restart(self_test_restart),
    .offset_trim_val(offset_trim_val));

  afcr_host_model u_host (.ref_clk(ref_clk), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .sdio_in(sdio_in));

  // Free-running 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d errors=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task wr(input logic [12:0] a, input logic [7:0] wd);
    u_host.xfer(1'b0, a, wd, r);
  endtask

  task rd(input logic [12:0] a);
    u_host.xfer(1'b1, a, 8'h00, r);
  endtask

  // Bit 1 standby, bit 0 full power-down; full power-down wins
  function automatic logic [1:0] pw(input logic pin, input logic ext,
    input logic [1:0] m);
    logic f;
    f = (pin && !ext) || m == 2'h1;
    pw = {!f && ((pin && ext) || m == 2'h2), f};
  endfunction

  // Pulse the divider sync and count cycles until it comes out
  task automatic phase_delay;
    k_seen = -1;
    @(negedge ref_clk);
    divider_sync_in = 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      #1;
      if (divider_sync_out === 1'b1 && k_seen < 0)
        k_seen = k;
      @(negedge ref_clk);
      divider_sync_in = 1'b0;
    end
  endtask

  // Watchdog so a stuck port cannot hang the run
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    srst = 1'b1;
    pdwn_pin = 1'b0;
    divider_sync_in = 1'b0;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk(duty_cycle_corrector_en, 16'h0001);
    chk({dev_standby, dev_full_power_down}, 16'h0000);
    for (int i = 0; i < NUM_SLOT; i++)
    begin
      rd(SLOT_ADDR[i]);
      chk(r, SLOT_RESET[i]);
    end
    rd(ADDR_CHAN_INDEX);
    chk(r, 16'h0003);
    wr(13'h007, 8'hA5);
    rd(13'h007);
    chk(r, 16'h0000);
    // Shadowed divide must wait for the transfer
    wr(13'h009, 8'h00);
    wr(13'h00B, 8'h05);
    chk(clk_div_sel, 16'h0000);
    rd(13'h00B);
    chk(r, 16'h0005);
    for (int v = 7; v >= 0; v--)
    begin
      wr(13'h00B, v[7:0]);
      wr(ADDR_TRANSFER, 8'h01);
      chk(clk_div_sel, v[2:0]);
      chk(duty_cycle_corrector_en, v != 0);
    end
    rd(ADDR_TRANSFER);
    chk(r, 16'h0000);
    // Per-channel power modes through the index
    eb = 2'h0;
    for (int c = 0; c < 4; c++)
    begin
      d = $random(seed);
      wr(ADDR_CHAN_INDEX, 8'h01);
      wr(13'h008, c[7:0]);
      wr(ADDR_CHAN_INDEX, 8'h02);
      wr(13'h008, {6'h00, d[1:0]});
      // Live copy still holds the previous pass until the transfer
      chk(dev_full_power_down[CH_B], eb[0]);
      chk(dev_standby[CH_B], eb[1]);
      wr(ADDR_TRANSFER, 8'h01);
      ea = pw(1'b0, 1'b0, c[1:0]);
      eb = pw(1'b0, 1'b0, d[1:0]);
      chk({dev_standby, dev_full_power_down},
        {eb[1], ea[1], eb[0], ea[0]});
    end
    // External pin role with random channel modes
    wr(ADDR_CHAN_INDEX, 8'h03);
    @(negedge ref_clk);
    pdwn_pin = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      d = $random(seed);
      wr(13'h008, {2'h0, e[0], 3'h0, d[1:0]});
      wr(ADDR_TRANSFER, 8'h01);
      ea = pw(1'b1, e[0], d[1:0]);
      chk({dev_standby, dev_full_power_down}, {{2{ea[1]}}, {2{ea[0]}}});
    end
    pdwn_pin = 1'b0;
    // Output mode fields, every format code
    for (int k = 0; k < 6; k++)
    begin
      d = $random(seed);
      d[1:0] = k[1:0];
      wr(13'h014, d);
      wr(ADDR_TRANSFER, 8'h01);
      chk({drive_reduced, output_lvds}, d[7:6]);
      chk({output_enable_n, output_invert}, {{2{d[4]}}, {2{d[2]}}});
      chk(twos_complement, {2{d[1:0] == FMT_TWOS}});
      chk(gray_code, {2{d[1:0] == FMT_GRAY}});
    end
    // Divider phase delay; code 7 is held at six cycles
    for (int p = 0; p < 8; p++)
    begin
      d = $random(seed);
      wr(13'h016, {d[7], 4'h0, p[2:0]});
      wr(ADDR_TRANSFER, 8'h01);
      chk(output_data_clock_invert, d[7]);
      chk(divider_phase, p[2:0]);
      phase_delay();
      chk(k_seen, (p == 7) ? 6 : p);
    end
    // Local copies steered by the index, first channel wins on read
    for (int k = 0; k < 2; k++)
    begin
      la[k] = $random(seed);
      lb[k] = $random(seed);
      lc[k] = $random(seed);
      wr(ADDR_CHAN_INDEX, k == 0 ? 8'h01 : 8'h02);
      wr(13'h00D, la[k] & 8'h37);
      wr(13'h00E, lb[k] & 8'h05);
      wr(13'h010, lc[k] & 8'h3F);
    end
    wr(ADDR_CHAN_INDEX, 8'h03);
    rd(13'h010);
    chk(r, lc[0] & 8'h3F);
    wr(ADDR_CHAN_INDEX, 8'h02);
    rd(13'h00D);
    chk(r, lb[0] & 8'h00 | la[1] & 8'h37);
    wr(ADDR_TRANSFER, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      chk(offset_trim_val[k], lc[k][5:0]);
      chk(test_pattern[k], la[k][2:0]);
      chk({long_prbs_generator_reset[k], short_prbs_generator_reset[k]},
        la[k][5:4]);
      chk({self_test_restart[k], self_test_en[k]},
        {lb[k][2], lb[k][0]});
    end
    conclude();
  end
endmodule
